/* sync_serial_port_map.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef SYNC_SERIAL_PORT_MAP_SVH
`define SYNC_SERIAL_PORT_MAP_SVH
`define SSP_OFS_CONTROL     4'h0
`define SSP_OFS_STATUS      4'h4
`define SSP_OFS_DATA        4'h8
`define SSP_OFS_SLAVE_ADDR  4'hC
`define SSP_BIT_WRITE_COLLISION        7
`define SSP_BIT_OVF         6
`define SSP_BIT_EN          5
`define SSP_BIT_CKP         4
`define SSP_ST_DA           5
`define SSP_ST_STOP         4
`define SSP_ST_START        3
`define SSP_ST_RW           2
`define SSP_ST_UA           1
`define SSP_ST_BF           0
`define SSP_CONTROL_RST     8'h00
`define SSP_STATUS_RST      8'h00
`define SSP_DIV4_HALF       7'h02
`define SSP_DIV16_HALF      7'h08
`define SSP_DIV64_HALF      7'h20
`define SSP_BITS_PER_WORD   4'h8
`endif

/* sync_serial_port_pkg.sv */
// Types shared by the synchronous serial port
package sync_serial_port_pkg;
    typedef enum logic [3:0] {
        MODE_MASTER_DIV4  = 4'h0,
        MODE_MASTER_DIV16 = 4'h1,
        MODE_MASTER_DIV64 = 4'h2,
        MODE_MASTER_TMR   = 4'h3,
        MODE_SLAVE_SEL    = 4'h4,
        MODE_SLAVE_NOSEL  = 4'h5,
        MODE_I2C_7BIT     = 4'h6,
        MODE_I2C_10BIT    = 4'h7,
        MODE_RSVD_8       = 4'h8,
        MODE_RSVD_9       = 4'h9,
        MODE_RSVD_A       = 4'hA,
        MODE_I2C_FW_MAST  = 4'hB,
        MODE_RSVD_C       = 4'hC,
        MODE_RSVD_D       = 4'hD,
        MODE_I2C_MM_7BIT  = 4'hE,
        MODE_I2C_MM_10BIT = 4'hF
    } port_mode_select_type;
endpackage : sync_serial_port_pkg

/* basic_sync_port.sv */
// Byte-wide synchronous serial port with Avalon-MM register access
//
// Behaviour
// - Modes 0000/0001/0010: SPI master, clock at system clock /4, /16, /64.
// - Mode 0011: SPI master clocked at half the timer-two output rate.
// - Modes 0100/0101: slave on pin clock; 0100 honours select, 0101 not.
// - Codes 0110,0111,1011,1110,1111 are I2C modes; 1000-1010,1100-1101 reserved.
// - Enable bit set hands pins to the port; clear returns them to I/O.
// - In SPI modes the polarity bit sets the idle clock level.
// - In I2C modes polarity 0 holds the I2C clock low, 1 releases it.
// - Buffer write during a transfer is dropped and sets sticky collision.
// - SPI slave byte into full buffer sets overflow, new byte lost.
// - I2C byte into full buffer sets overflow; only software clears it.
// - Eight-bit words shift MSB first, transmit and receive together.
// - Completed byte goes to buffer, sets buffer-full and interrupt flag.
// - Reading the data buffer clears buffer-full.
// - In SPI master mode each buffer write while idle launches one byte exchange.
// - I2C data/address bit shows whether last byte was data or address.
// - Stop and start bits show last condition; cleared by reset/disable.
// - Read/write bit captured at address match, valid until start/stop/nack.
// - Update-address bit set when 10-bit slave needs address reload.
// - In I2C a buffer write sets buffer-full; it stays 1 until the data buffer is read.
// - Status bits 7:6 always read zero.
// - Shift register is reached only through the data buffer address.
// - Data driven on programmed edge, sampled on opposite edge.
// - Select high floats serial out; reassert resumes at same bit.
// - Reset disables the port and abandons any transfer.
`timescale 1ns/1ns
`include "sync_serial_port_map.svh"
module basic_sync_port (
    input  wire logic                              clk_sys_i,
    input  wire logic                              rst_i,
    input  wire logic [3:0]                        avs_address_i,
    input  wire logic                              avs_read_i,
    input  wire logic                              avs_write_i,
    input  wire logic [31:0]                       avs_writedata_i,
    input  wire logic [3:0]                        avs_byteenable_i,
    output logic      [31:0]                       avs_readdata_o,
    output logic                                   avs_waitrequest_o,
    input  wire logic                              timer_two_i,
    input  wire logic                              sck_i,
    output logic                                   sck_o,
    output logic                                   sck_oe_n_o,
    input  wire logic                              serial_in_i,
    output logic                                   serial_out_o,
    output logic                                   serial_out_oe_n_o,
    input  wire logic                              select_n_i,
    input  wire logic                              i2c_scl_i,
    input  wire logic                              i2c_sda_i,
    output logic                                   i2c_scl_oe_n_o,
    output logic                                   pins_to_port_o,
    output logic                                   serial_irq_flag_o,
    output sync_serial_port_pkg::port_mode_select_type port_mode_o
);
    import sync_serial_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, two flops before any logic
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= 5'h1F;
            sync_q <= 5'h1F;
        end else begin
            meta_q <= {timer_two_i, sck_i, serial_in_i, select_n_i,
                       i2c_scl_i};
            sync_q <= meta_q;
        end
    end
    wire tmr_s    = sync_q[4];
    wire sck_s    = sync_q[3];
    wire sdi_s    = sync_q[2];
    wire ssn_s    = sync_q[1];
    wire scl_s    = sync_q[0];
    logic       tmr_last_q;
    logic       sck_last_q;
    logic       scl_last_q;
    logic       sda_meta_q;
    logic       sda_s_q;
    logic       sda_last_q;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] control_q;
    logic [7:0] data_buffer_q;
    logic [7:0] shift_register_q;
    logic [7:0] slave_address_reg_q;
    logic [3:0] bit_cnt_q;
    logic       busy_q;
    logic       rx_buffer_full_q;
    logic       irq_q;
    logic       da_q, stop_q, start_q, rw_q, ua_q;
    logic [6:0] div_cnt_q;
    logic       tmr_half_q;
    logic       sck_int_q;
    logic       phase_q;
    logic       sample_q;

    wire port_enable = control_q[`SSP_BIT_EN];
    wire clock_polarity = control_q[`SSP_BIT_CKP];
    wire [3:0] mode = control_q[3:0];
    wire is_master = port_enable && (mode <= MODE_MASTER_TMR);
    wire is_slave  = port_enable && (mode == MODE_SLAVE_SEL ||
                                     mode == MODE_SLAVE_NOSEL);
    wire is_i2c    = port_enable && (mode == MODE_I2C_7BIT ||
                     mode == MODE_I2C_10BIT || mode == MODE_I2C_FW_MAST ||
                     mode == MODE_I2C_MM_7BIT ||
                     mode == MODE_I2C_MM_10BIT);
    wire sel_ok    = (mode != MODE_SLAVE_SEL) || !ssn_s;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; every access answers in one wait cycle
    logic       ack_q;
    wire req      = (avs_read_i || avs_write_i) && !ack_q;
    wire take     = (avs_read_i || avs_write_i) && ack_q;
    wire hit_ctl  = avs_address_i == `SSP_OFS_CONTROL;
    wire hit_st   = avs_address_i == `SSP_OFS_STATUS;
    wire hit_dat  = avs_address_i == `SSP_OFS_DATA;
    wire hit_adr  = avs_address_i == `SSP_OFS_SLAVE_ADDR;
    wire lane0    = avs_byteenable_i[0];
    wire wr_ctl   = take && avs_write_i && hit_ctl && lane0;
    wire wr_dat   = take && avs_write_i && hit_dat && lane0;
    wire wr_adr   = take && avs_write_i && hit_adr && lane0;
    wire rd_dat   = take && avs_read_i && hit_dat;
    wire [7:0] status_w = {2'b00, da_q, stop_q, start_q, rw_q, ua_q,
                           rx_buffer_full_q};
    wire [7:0] rdata_w = hit_ctl ? control_q :
                         hit_st  ? status_w :
                         hit_dat ? data_buffer_q :
                         hit_adr ? slave_address_reg_q : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Shift clock generation and edge detection
    function automatic logic [6:0] half_period(input logic [3:0] m);
        if (m == MODE_MASTER_DIV4)
            half_period = `SSP_DIV4_HALF;
        else if (m == MODE_MASTER_DIV16)
            half_period = `SSP_DIV16_HALF;
        else
            half_period = `SSP_DIV64_HALF;
    endfunction : half_period

    wire tmr_rise  = tmr_s && !tmr_last_q;
    wire div_tick  = (mode == MODE_MASTER_TMR) ? tmr_rise :
                     (div_cnt_q == half_period(mode) - 7'h01);
    wire m_tick    = is_master && busy_q && div_tick;
    wire m_lead    = m_tick && !phase_q;
    wire m_trail   = m_tick && phase_q;
    wire s_rise    = sck_s && !sck_last_q;
    wire s_fall    = !sck_s && sck_last_q;
    // Leading edge leaves the idle level; sample there, drive on trailing
    wire s_lead    = clock_polarity ? s_fall : s_rise;
    wire s_trail   = clock_polarity ? s_rise : s_fall;
    wire do_sample = is_master ? m_lead :
                     (is_slave && sel_ok && s_lead);
    wire do_shift  = is_master ? m_trail :
                     (is_slave && sel_ok && s_trail);
    // Master reads the line at its trailing tick: the synchroniser delay
    // makes that the level seen at the leading pin edge
    wire in_bit    = is_master ? sdi_s : sample_q;
    wire last_bit  = bit_cnt_q == (`SSP_BITS_PER_WORD - 4'h1);
    wire byte_done = do_shift && last_bit;

    ////////////////////////////////////////////////////////////////////////
    // I2C condition detection, kept to flags only
    wire scl_rise   = scl_s && !scl_last_q;
    wire i2c_start  = is_i2c && scl_s && sda_last_q && !sda_s_q;
    wire i2c_stop   = is_i2c && scl_s && !sda_last_q && sda_s_q;
    logic [3:0] i2c_cnt_q;
    logic       i2c_addr_ph_q;
    logic [7:0] i2c_sr_q;
    wire i2c_byte   = is_i2c && scl_rise && i2c_cnt_q == 4'h7;
    wire [7:0] i2c_word = {i2c_sr_q[6:0], sda_s_q};
    wire adr_match  = i2c_byte && i2c_addr_ph_q &&
                      i2c_word[7:1] == slave_address_reg_q[7:1];
    wire ten_bit    = mode == MODE_I2C_10BIT || mode == MODE_I2C_MM_10BIT;

    ////////////////////////////////////////////////////////////////////////
    // Sequential logic
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            tmr_last_q <= 1'b1;
            sck_last_q <= 1'b1;
            scl_last_q <= 1'b1;
            sda_meta_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_last_q <= 1'b1;
        end else begin
            ack_q <= req;
            tmr_last_q <= tmr_s;
            sck_last_q <= sck_s;
            scl_last_q <= scl_s;
            sda_meta_q <= i2c_sda_i;
            sda_s_q <= sda_meta_q;
            sda_last_q <= sda_s_q;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            control_q <= `SSP_CONTROL_RST;
            slave_address_reg_q <= 8'h00;
            data_buffer_q <= 8'h00;
            rx_buffer_full_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            if (wr_ctl) begin
                control_q[5:0] <= avs_writedata_i[5:0];
            end
            if (wr_adr) begin
                slave_address_reg_q <= avs_writedata_i[7:0];
            end
            // Collision: sticky, hardware set wins over software clear
            control_q[`SSP_BIT_WRITE_COLLISION] <= (wr_dat && busy_q) ||
                (control_q[`SSP_BIT_WRITE_COLLISION] &&
                 !(wr_ctl && !avs_writedata_i[`SSP_BIT_WRITE_COLLISION]));
            control_q[`SSP_BIT_OVF] <=
                (byte_done && is_slave && rx_buffer_full_q) ||
                (i2c_byte && rx_buffer_full_q) ||
                (control_q[`SSP_BIT_OVF] &&
                 !(wr_ctl && !avs_writedata_i[`SSP_BIT_OVF]));
            if (wr_dat && !busy_q) begin
                data_buffer_q <= avs_writedata_i[7:0];
            end else if (byte_done && !(is_slave && rx_buffer_full_q)) begin
                data_buffer_q <= {shift_register_q[6:0], in_bit};
            end else if (i2c_byte && !rx_buffer_full_q) begin
                data_buffer_q <= i2c_word;
            end
            if (byte_done || i2c_byte) begin
                rx_buffer_full_q <= 1'b1;
            end else if (rd_dat) begin
                rx_buffer_full_q <= 1'b0;
            end else if (wr_dat && !busy_q && is_i2c) begin
                rx_buffer_full_q <= 1'b1;
            end
            if (byte_done || i2c_byte || i2c_start || i2c_stop) begin
                irq_q <= 1'b1;
            end else if (take && avs_write_i && hit_st && lane0 &&
                         !avs_writedata_i[0]) begin
                irq_q <= 1'b0;
            end
        end
    end

    // Shift engine
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            shift_register_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            busy_q <= 1'b0;
            div_cnt_q <= 7'h00;
            phase_q <= 1'b0;
            sck_int_q <= 1'b0;
            sample_q <= 1'b0;
        end else if (!port_enable) begin
            busy_q <= 1'b0;
            bit_cnt_q <= 4'h0;
            phase_q <= 1'b0;
            div_cnt_q <= 7'h00;
            sck_int_q <= clock_polarity;
        end else begin
            div_cnt_q <= div_tick ? 7'h00 : div_cnt_q + 7'h01;
            if (wr_dat && !busy_q && !is_i2c) begin
                shift_register_q <= avs_writedata_i[7:0];
                busy_q <= is_master;
                bit_cnt_q <= 4'h0;
                phase_q <= 1'b0;
            end
            if (m_tick) begin
                phase_q <= !phase_q;
                sck_int_q <= !sck_int_q;
            end
            if (!busy_q) begin
                sck_int_q <= clock_polarity;
            end
            if (do_sample) begin
                sample_q <= sdi_s;
            end
            if (do_shift) begin
                shift_register_q <= {shift_register_q[6:0], in_bit};
                bit_cnt_q <= last_bit ? 4'h0 : bit_cnt_q + 4'h1;
                if (last_bit && is_master) begin
                    busy_q <= 1'b0;
                end
            end
            if (is_slave && do_sample && bit_cnt_q == 4'h0) begin
                busy_q <= 1'b1;
            end
            if (is_slave && byte_done) begin
                busy_q <= 1'b0;
            end
        end
    end

    // I2C status flags
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            {da_q, stop_q, start_q, rw_q, ua_q} <= 5'h00;
            i2c_cnt_q <= 4'h0;
            i2c_addr_ph_q <= 1'b0;
            i2c_sr_q <= 8'h00;
        end else if (!is_i2c) begin
            {da_q, stop_q, start_q, rw_q, ua_q} <= 5'h00;
            i2c_cnt_q <= 4'h0;
            i2c_addr_ph_q <= 1'b0;
        end else begin
            if (i2c_start || i2c_stop) begin
                start_q <= i2c_start;
                stop_q <= i2c_stop;
                rw_q <= 1'b0;
                i2c_cnt_q <= 4'h0;
                i2c_addr_ph_q <= i2c_start;
            end else if (scl_rise) begin
                i2c_sr_q <= i2c_word;
                i2c_cnt_q <= (i2c_cnt_q == 4'h8) ? 4'h0 : i2c_cnt_q + 4'h1;
                if (i2c_cnt_q == 4'h8 && sda_s_q) begin
                    rw_q <= 1'b0;
                end
            end
            if (i2c_byte) begin
                da_q <= !i2c_addr_ph_q;
                i2c_addr_ph_q <= 1'b0;
            end
            if (adr_match) begin
                rw_q <= i2c_word[0];
                ua_q <= ten_bit;
            end else if (wr_adr) begin
                ua_q <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
            avs_waitrequest_o <= 1'b1;
            sck_o <= 1'b0;
            sck_oe_n_o <= 1'b1;
            serial_out_o <= 1'b0;
            serial_out_oe_n_o <= 1'b1;
            i2c_scl_oe_n_o <= 1'b1;
            pins_to_port_o <= 1'b0;
            serial_irq_flag_o <= 1'b0;
            port_mode_o <= MODE_MASTER_DIV4;
        end else begin
            avs_readdata_o <= {24'h000000, rdata_w};
            avs_waitrequest_o <= !req;
            sck_o <= sck_int_q;
            sck_oe_n_o <= !is_master;
            serial_out_o <= shift_register_q[7];
            serial_out_oe_n_o <= !(is_master ||
                                   (is_slave && sel_ok));
            // Stretch while the polarity bit is low
            i2c_scl_oe_n_o <= !(is_i2c && !clock_polarity);
            pins_to_port_o <= port_enable;
            serial_irq_flag_o <= irq_q;
            port_mode_o <= port_mode_select_type'(mode);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence wr_while_busy_s;
        wr_dat && busy_q && !do_shift;
    endsequence
    collision_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_while_busy_s |=> control_q[`SSP_BIT_WRITE_COLLISION] &&
        $stable(shift_register_q))
        else $error("collision flag not set");
    read_clear_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rd_dat && !byte_done && !i2c_byte |=> !rx_buffer_full_q)
        else $error("buffer full not cleared by read");
    byte_full_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        byte_done |=> rx_buffer_full_q && irq_q)
        else $error("byte done without flags");
    master_ovf_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        is_master && !control_q[`SSP_BIT_OVF] && !i2c_byte
        |=> !control_q[`SSP_BIT_OVF])
        else $error("overflow set in master mode");
    status_top_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        status_w[7:6] == 2'b00)
        else $error("unused status bits set");
    disable_clr_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !port_enable |=> !start_q && !stop_q && !busy_q)
        else $error("flags survive disable");
    launch_busy_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_dat && !busy_q && is_master |=> busy_q)
        else $error("master write did not launch");
    idle_clk_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        is_master && !busy_q
        |=> ##1 sck_o == $past(clock_polarity, 2))
        else $error("idle clock level wrong");
    select_float_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        mode == MODE_SLAVE_SEL && ssn_s && port_enable
        |=> serial_out_oe_n_o)
        else $error("serial out driven while deselected");
endmodule : basic_sync_port

/* spi_far_end.sv */
// Far-end SPI device that exchanges one byte per frame with the port
`timescale 1ns/1ns
module spi_far_end (
    input  wire logic       sck_i,
    input  wire logic       ckp_i,
    input  wire logic       active_i,
    input  wire logic [7:0] tx_byte_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    output logic [7:0]      rx_byte_o
);
    logic [2:0] idx_q;
    initial idx_q = 3'h0;
    initial rx_byte_o = 8'h00;
    // Leading edge samples, trailing edge moves to the next bit
    always @(sck_i) begin
        if (active_i && sck_i !== ckp_i) begin
            rx_byte_o = {rx_byte_o[6:0], mosi_i};
        end else if (active_i) begin
            idx_q = idx_q + 3'h1;
        end
    end
    // Outside a frame the line shows the inverse, so stale bits never match
    assign miso_o = active_i ? tx_byte_i[3'h7 - idx_q]
                             : ~tx_byte_i[3'h7 - idx_q];
endmodule : spi_far_end

/* basic_sync_port_tb_top.sv */
// Self-checking bench for the synchronous serial port
`timescale 1ns/1ns
`include "sync_serial_port_map.svh"
module basic_sync_port_tb_top;
    import sync_serial_port_pkg::*;
    localparam logic [3:0] a_ctl = `SSP_OFS_CONTROL, a_st = `SSP_OFS_STATUS;
    localparam logic [3:0] a_dat = `SSP_OFS_DATA;
    logic        clk_sys_i, rst_i, avs_read_i, avs_write_i, timer_two_i;
    logic        sck_drv, far_on, sck_o, sck_oe_n_o, serial_in_i;
    logic        serial_out_o, serial_out_oe_n_o, i2c_scl_oe_n_o;
    logic        pins_to_port_o, serial_irq_flag_o, avs_waitrequest_o;
    logic [3:0]  avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o, rd;
    logic [7:0]  far_tx, far_rx;
    int          fails, checks, p;
    port_mode_select_type port_mode_o;
    wire logic   sck_i = sck_oe_n_o ? sck_drv : sck_o;
    // Rows: control byte, then idle clock, clock oe_n, I2C clock oe_n, pins
    logic [11:0] rows [15] = '{12'h203, 12'h30B, 12'h213, 12'h223, 12'h233,
        12'h247, 12'h357, 12'h265, 12'h275, 12'h3B7, 12'h3E7, 12'h3F7,
        12'h006, 12'h046, 12'h287};
    // Rows: control byte, clock period in system cycles
    logic [15:0] xf [4] = '{16'h2004, 16'h2110, 16'h2240, 16'h2314};
    basic_sync_port DUT (.clk_sys_i, .rst_i, .avs_address_i, .avs_read_i,
        .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF),
        .avs_readdata_o, .avs_waitrequest_o, .timer_two_i, .sck_i, .sck_o,
        .sck_oe_n_o, .serial_in_i, .serial_out_o, .serial_out_oe_n_o,
        .select_n_i(1'b1), .i2c_scl_i(1'b1), .i2c_sda_i(1'b1),
        .i2c_scl_oe_n_o, .pins_to_port_o, .serial_irq_flag_o, .port_mode_o);
    spi_far_end far (.sck_i, .ckp_i(1'b0), .active_i(far_on),
        .tx_byte_i(far_tx), .mosi_i(serial_out_o), .miso_o(serial_in_i),
        .rx_byte_o(far_rx));
    initial begin
        clk_sys_i = 1'b0;
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    // Timer output toggles every five clocks, one rise per 10 cycles
    initial begin
        timer_two_i = 1'b0;
        forever begin
            repeat (5) @(posedge clk_sys_i);
            timer_two_i <= ~timer_two_i;
        end
    end
    task automatic final_report();
        if (fails == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address_i <= a;
        avs_writedata_i <= {24'h000000, d};
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        if (avs_waitrequest_o !== 1'b0) begin
            fails++;
            final_report();
        end
        @(posedge clk_sys_i);
    endtask : bus
    task automatic rise(output int c);
        logic prev;
        c = 0;
        prev = sck_o;
        forever begin
            @(posedge clk_sys_i);
            c++;
            if (sck_o === 1'b1 && prev === 1'b0) return;
            prev = sck_o;
            if (c > 300) begin
                fails++;
                final_report();
            end
        end
    endtask : rise
    task automatic wait_full();
        for (int n = 0; n < 300; n++) begin
            bus(1'b0, a_st, 8'h00);
            if (rd[`SSP_ST_BF] === 1'b1) return;
        end
        fails++;
        final_report();
    endtask : wait_full
    initial begin
        {rst_i, avs_read_i, avs_write_i, sck_drv, far_on} = 5'b10000;
        {avs_address_i, avs_writedata_i, far_tx} = '0;
        repeat (20) @(posedge clk_sys_i);
        check({sck_oe_n_o, serial_out_oe_n_o, i2c_scl_oe_n_o, pins_to_port_o,
            serial_irq_flag_o, avs_waitrequest_o}, 32'h39);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        bus(1'b0, a_st, 8'h00);
        check(rd, 32'h0);
        foreach (rows[i]) begin
            bus(1'b1, a_ctl, rows[i][11:4]);
            bus(1'b0, a_ctl, 8'h00);
            check(rd, {24'h0, rows[i][11:4]});
            check({sck_oe_n_o ? rows[i][3] : sck_o, sck_oe_n_o, i2c_scl_oe_n_o,
                pins_to_port_o, port_mode_o}, {rows[i][3:0], rows[i][7:4]});
        end
        foreach (xf[i]) begin
            far_tx <= 8'hA5 ^ xf[i][7:0];
            bus(1'b1, a_ctl, xf[i][15:8]);
            far_on <= 1'b1;
            bus(1'b1, a_dat, 8'h3C ^ xf[i][7:0]);
            rise(p);
            rise(p);
            check(p, {24'h0, xf[i][7:0]});
            wait_full();
            far_on <= 1'b0;
            check(far_rx, 8'h3C ^ xf[i][7:0]);
            bus(1'b0, a_dat, 8'h00);
            check(rd, {24'h0, 8'hA5 ^ xf[i][7:0]});
            bus(1'b0, a_st, 8'h00);
            check({23'h0, rd[7:0], serial_irq_flag_o}, 32'h1);
            bus(1'b1, a_st, 8'h00);
            @(posedge clk_sys_i);
            check(serial_irq_flag_o, 32'h0);
        end
        bus(1'b1, a_ctl, 8'h20);
        far_on <= 1'b1;
        bus(1'b1, a_dat, 8'hC3);
        bus(1'b1, a_dat, 8'h18);
        wait_full();
        check(far_rx, 8'hC3);
        bus(1'b1, a_dat, 8'h7E);
        repeat (40) @(posedge clk_sys_i);
        bus(1'b0, a_ctl, 8'h00);
        check(rd, 32'hA0);
        far_on <= 1'b0;
        bus(1'b1, a_ctl, 8'h25);
        bus(1'b0, a_ctl, 8'h00);
        check(rd, 32'h25);
        bus(1'b0, a_dat, 8'h00);
        check(rd, 32'hB1);
        far_tx <= 8'h96;
        far_on <= 1'b1;
        repeat (32) begin
            sck_drv <= !sck_drv;
            repeat (8) @(posedge clk_sys_i);
        end
        far_on <= 1'b0;
        bus(1'b0, a_ctl, 8'h00);
        check(rd, 32'h65);
        bus(1'b0, a_dat, 8'h00);
        check(rd, 32'h96);
        bus(1'b1, a_ctl, 8'h22);
        bus(1'b1, a_dat, 8'h55);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        bus(1'b0, a_ctl, 8'h00);
        check({22'h0, rd[7:0], pins_to_port_o, sck_oe_n_o}, 32'h1);
        final_report();
    end
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        fails++;
        final_report();
    end
endmodule : basic_sync_port_tb_top
